// file: src/t1pm_consts.svh
// Register indices, field positions, reset values and timing counts of the monitor bank
`ifndef T1PM_CONSTS_SVH
`define T1PM_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define T1PM_IDX_LOF      14'h090a
`define T1PM_IDX_ALIGNMENT_CHANGE_EVENT     14'h090b
`define T1PM_IDX_FCS1     14'h090c
`define T1PM_IDX_PAT_HI   14'h090d
`define T1PM_IDX_PAT_LO   14'h090e
`define T1PM_IDX_SLIP     14'h090f
`define T1PM_IDX_IRQ_STAT 14'h0918
`define T1PM_IDX_IRQ_MASK 14'h0919

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define T1PM_CNT8_RST     8'h00
`define T1PM_CNT16_RST    16'h0000
`define T1PM_EV_RST       5'h00

// ----------------------------------------------------------------
// Event bit positions in status and mask
// ----------------------------------------------------------------
`define T1PM_EV_LOF       0
`define T1PM_EV_ALIGNMENT_CHANGE_EVENT      1
`define T1PM_EV_FCS1      2
`define T1PM_EV_PAT       3
`define T1PM_EV_SLIP      4
`define T1PM_EV_W         5

// ----------------------------------------------------------------
// Bus timing: cycles from access phase to pready
// ----------------------------------------------------------------
`define T1PM_APB_WAIT     1

`endif

// file: src/t1pm_pkg.sv
// Types shared by the performance monitor counter bank
package t1pm_pkg;
  typedef logic [7:0]  t1pm_byte_t;
  typedef logic [15:0] t1pm_word_t;
  typedef logic [13:0] t1pm_idx_t;

  // Bus slave phase
  typedef enum logic [0:0] {
    APB_IDLE,
    APB_RESP
  } t1pm_apb_e;

  // Upper/lower byte read pairing of the wide counter
  typedef enum logic [0:0] {
    PAIR_OPEN,
    PAIR_ARMED
  } t1pm_pair_e;
endpackage

// file: src/t1pm_sat_counter.sv
// Saturating clear-on-read event counter
module t1pm_sat_counter
  import t1pm_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             inc,
  input  wire logic             clr,
  output logic [WIDTH-1:0]      count
);
  logic [WIDTH-1:0] count_r;
  localparam logic [WIDTH-1:0] MAXV = '1;

  // Clear opens a new interval; a coinciding event is its first count
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      count_r <= '0;
    end else if (clr) begin
      count_r <= inc ? WIDTH'(1) : '0;
    end else if (inc && (count_r != MAXV)) begin
      count_r <= count_r + WIDTH'(1);
    end
  end

  assign count = count_r;
endmodule // t1pm_sat_counter

// file: src/t1pm_counters.sv
// Performance monitor event counter bank with APB register access
`include "t1pm_consts.svh"

// Functional notes
// - Count each loss-of-frame declaration once
// - Counters hold events since read; read clears
// - Count alignment changes versus off-line candidate
// - Count link controller 1 FCS errors
// - 16-bit pattern errors, high then low byte
// - Upper then lower read clears wide count
// - Count transmit slip frame repeat or drop
module t1pm_counters
  import t1pm_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Event sources
  input  wire logic        loss_of_frame_state,
  input  wire logic        alignment_change_event,
  input  wire logic        link_ctrl1_fcs_error,
  input  wire logic        pattern_bit_error,
  input  wire logic        transmit_slip_event,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Word index of a byte address
  function automatic t1pm_idx_t word_index(input logic [15:0] addr);
    word_index = addr[15:2];
  endfunction

  // True for every index this bank answers
  function automatic logic is_mapped(input t1pm_idx_t idx);
    case (idx)
      `T1PM_IDX_LOF, `T1PM_IDX_ALIGNMENT_CHANGE_EVENT, `T1PM_IDX_FCS1,
      `T1PM_IDX_PAT_HI, `T1PM_IDX_PAT_LO, `T1PM_IDX_SLIP,
      `T1PM_IDX_IRQ_STAT, `T1PM_IDX_IRQ_MASK: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Bus slave phase
  // ----------------------------------------------------------------
  t1pm_apb_e   apb_r;
  t1pm_idx_t   idx;
  logic        access;
  logic        rd_fire;
  logic        wr_fire;
  logic        bad_addr;
  logic        err_r;
  logic [31:0] prdata_r;

  assign idx      = word_index(paddr);
  assign bad_addr = (paddr[1:0] != 2'b00) || !is_mapped(idx);
  assign access   = psel && penable && (apb_r == APB_IDLE);
  assign rd_fire  = access && !pwrite && !bad_addr;
  assign wr_fire  = access && pwrite && !bad_addr;

  // One wait state so that read data comes straight from a flip-flop
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      apb_r <= APB_IDLE;
    end else begin
      case (apb_r)
        APB_IDLE: if (access) apb_r <= APB_RESP;
        APB_RESP: apb_r <= APB_IDLE;
        default:  apb_r <= APB_IDLE;
      endcase
    end
  end

  // Error flag for unmapped or unaligned addresses
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      err_r <= 1'b0;
    end else if (access) begin
      err_r <= bad_addr;
    end
  end

  assign pready  = (apb_r == APB_RESP);
  assign pslverr = pready && err_r;
  assign prdata  = prdata_r;

  // ----------------------------------------------------------------
  // Event conditioning
  // ----------------------------------------------------------------
  logic lof_prev_r;
  logic lof_declare;

  // The framer holds loss of frame as a level; count only its onset
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      lof_prev_r <= 1'b0;
    end else begin
      lof_prev_r <= loss_of_frame_state;
    end
  end

  assign lof_declare = loss_of_frame_state && !lof_prev_r;

  // ----------------------------------------------------------------
  // Eight-bit counters
  // ----------------------------------------------------------------
  t1pm_byte_t lof_cnt;
  t1pm_byte_t alignment_change_event_cnt;
  t1pm_byte_t fcs_cnt;
  t1pm_byte_t slip_cnt;
  logic       rd_lof;
  logic       rd_alignment_change_event;
  logic       rd_fcs;
  logic       rd_slip;

  // Reading a counter clears it
  assign rd_lof  = rd_fire && (idx == `T1PM_IDX_LOF);
  assign rd_alignment_change_event = rd_fire && (idx == `T1PM_IDX_ALIGNMENT_CHANGE_EVENT);
  assign rd_fcs  = rd_fire && (idx == `T1PM_IDX_FCS1);
  assign rd_slip = rd_fire && (idx == `T1PM_IDX_SLIP);

  t1pm_sat_counter #(.WIDTH(8)) u_lof (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .inc     (lof_declare),
    .clr     (rd_lof),
    .count   (lof_cnt)
  );

  t1pm_sat_counter #(.WIDTH(8)) u_alignment_change_event (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .inc     (alignment_change_event),
    .clr     (rd_alignment_change_event),
    .count   (alignment_change_event_cnt)
  );

  t1pm_sat_counter #(.WIDTH(8)) u_fcs (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .inc     (link_ctrl1_fcs_error),
    .clr     (rd_fcs),
    .count   (fcs_cnt)
  );

  t1pm_sat_counter #(.WIDTH(8)) u_slip (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .inc     (transmit_slip_event),
    .clr     (rd_slip),
    .count   (slip_cnt)
  );

  // ----------------------------------------------------------------
  // Sixteen-bit pattern error counter
  // ----------------------------------------------------------------
  t1pm_word_t pat_cnt_r;
  t1pm_word_t pat_snap_r;
  t1pm_byte_t pat_low_r;
  t1pm_pair_e pair_r;
  logic       rd_pat_hi;
  logic       rd_pat_lo;
  logic       pat_clear;
  logic       pat_inc;

  assign rd_pat_hi = rd_fire && (idx == `T1PM_IDX_PAT_HI);
  assign rd_pat_lo = rd_fire && (idx == `T1PM_IDX_PAT_LO);
  assign pat_clear = rd_pat_lo && (pair_r == PAIR_ARMED);
  assign pat_inc   = pattern_bit_error && (pat_cnt_r != 16'hffff);

  // Clearing removes only what the host saw, so errors arriving
  // between the two byte reads stay in the count
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pat_cnt_r <= `T1PM_CNT16_RST;
    end else if (pat_clear) begin
      pat_cnt_r <= pat_cnt_r - pat_snap_r + {15'h0000, pattern_bit_error};
    end else if (pat_inc) begin
      pat_cnt_r <= pat_cnt_r + 16'h0001;
    end
  end

  // Upper read takes a snapshot and holds the lower byte
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pat_snap_r <= `T1PM_CNT16_RST;
      pat_low_r  <= `T1PM_CNT8_RST;
    end else if (rd_pat_hi) begin
      pat_snap_r <= pat_cnt_r;
      pat_low_r  <= pat_cnt_r[7:0];
    end
  end

  // A lower read only clears when it follows an upper read
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pair_r <= PAIR_OPEN;
    end else begin
      case (pair_r)
        PAIR_OPEN:  if (rd_pat_hi) pair_r <= PAIR_ARMED;
        PAIR_ARMED: if (rd_pat_lo) pair_r <= PAIR_OPEN;
        default:    pair_r <= PAIR_OPEN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [`T1PM_EV_W-1:0] ev_vec;
  logic [`T1PM_EV_W-1:0] stat_r;
  logic [`T1PM_EV_W-1:0] mask_r;
  logic                  rd_stat;

  assign ev_vec[`T1PM_EV_LOF]  = lof_declare;
  assign ev_vec[`T1PM_EV_ALIGNMENT_CHANGE_EVENT] = alignment_change_event;
  assign ev_vec[`T1PM_EV_FCS1] = link_ctrl1_fcs_error;
  assign ev_vec[`T1PM_EV_PAT]  = pattern_bit_error;
  assign ev_vec[`T1PM_EV_SLIP] = transmit_slip_event;
  assign rd_stat = rd_fire && (idx == `T1PM_IDX_IRQ_STAT);

  // Sticky bits; a new event wins over the clearing read
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      stat_r <= `T1PM_EV_RST;
    end else if (rd_stat) begin
      stat_r <= ev_vec;
    end else begin
      stat_r <= stat_r | ev_vec;
    end
  end

  // Mask written by software
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mask_r <= `T1PM_EV_RST;
    end else if (wr_fire && (idx == `T1PM_IDX_IRQ_MASK)) begin
      mask_r <= pwdata[`T1PM_EV_W-1:0];
    end
  end

  assign irq = |(stat_r & mask_r);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] rd_val;

  // Bits above each register's width read as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    case (idx)
      `T1PM_IDX_LOF:      rd_val[7:0] = lof_cnt;
      `T1PM_IDX_ALIGNMENT_CHANGE_EVENT:     rd_val[7:0] = alignment_change_event_cnt;
      `T1PM_IDX_FCS1:     rd_val[7:0] = fcs_cnt;
      `T1PM_IDX_PAT_HI:   rd_val[7:0] = pat_cnt_r[15:8];
      `T1PM_IDX_PAT_LO:   rd_val[7:0] = (pair_r == PAIR_ARMED) ?
                                        pat_low_r : pat_cnt_r[7:0];
      `T1PM_IDX_SLIP:     rd_val[7:0] = slip_cnt;
      `T1PM_IDX_IRQ_STAT: rd_val[`T1PM_EV_W-1:0] = stat_r;
      `T1PM_IDX_IRQ_MASK: rd_val[`T1PM_EV_W-1:0] = mask_r;
      default:            rd_val = 32'h0000_0000;
    endcase
  end

  // Captured on the same edge that clears the counter
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (access) begin
      prdata_r <= rd_fire ? rd_val : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  lof_once_a: assert property (
    lof_declare && !rd_lof && (lof_cnt != 8'hff)
    |=> (lof_cnt == $past(lof_cnt) + 8'h01) && !lof_declare)
    else $error("loss of frame not counted once");

  read_clear_a: assert property (
    rd_lof && !lof_declare |=> (lof_cnt == 8'h00) && pready)
    else $error("counter not cleared by read");

  alignment_change_event_count_a: assert property (
    alignment_change_event && !rd_alignment_change_event && (alignment_change_event_cnt != 8'hff)
    |=> alignment_change_event_cnt == $past(alignment_change_event_cnt) + 8'h01)
    else $error("alignment change not counted");

  fcs_count_a: assert property (
    link_ctrl1_fcs_error && !rd_fcs && (fcs_cnt != 8'hff)
    |=> fcs_cnt == $past(fcs_cnt) + 8'h01)
    else $error("fcs error not counted");

  pat_high_a: assert property (
    rd_pat_hi |=> (prdata[7:0] == $past(pat_cnt_r[15:8])) && pready)
    else $error("upper byte read wrong");

  pat_clear_a: assert property (
    pat_clear && !pattern_bit_error
    |=> pat_cnt_r == $past(pat_cnt_r) - $past(pat_snap_r))
    else $error("wide counter not cleared by pair");

  low_latch_a: assert property (
    rd_pat_lo && (pair_r == PAIR_ARMED)
    |=> prdata[7:0] == $past(pat_low_r))
    else $error("lower byte not latched");

  slip_count_a: assert property (
    transmit_slip_event && !rd_slip && (slip_cnt != 8'hff)
    |=> slip_cnt == $past(slip_cnt) + 8'h01)
    else $error("transmit slip not counted");

  sat_hold_a: assert property (
    (fcs_cnt == 8'hff) && !rd_fcs |=> fcs_cnt == 8'hff)
    else $error("counter wrapped");

  clear_collide_a: assert property (
    rd_fcs && link_ctrl1_fcs_error |=> fcs_cnt == 8'h01)
    else $error("event lost during clearing read");

  stat_sticky_a: assert property (
    ev_vec[`T1PM_EV_SLIP] |=> stat_r[`T1PM_EV_SLIP]
    ##1 (stat_r[`T1PM_EV_SLIP] || $past(rd_stat)))
    else $error("status bit not sticky");

  pair_read_c: cover property (rd_pat_hi ##[1:8] rd_pat_lo);
  lof_collide_c: cover property (rd_lof && lof_declare);
  irq_seen_c: cover property ($rose(irq));
  bad_addr_c: cover property (pslverr);

endmodule // t1pm_counters

// file: tb/t1_perf_monitor_event_counters_test.sv
// Self-checking testbench of the performance monitor counter bank
`include "t1pm_consts.svh"

module t1_perf_monitor_event_counters_test
  import t1pm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals and design instance
  // ----------------------------------------------------------------
  logic        clk_sys;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [4:0]  ev;
  int          miscompares;
  int          cmp_count;
  int          cycles;
  logic [31:0] rd;
  logic        err;

  t1pm_counters uut (
    .clk_sys                (clk_sys),
    .resetn                 (resetn),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .loss_of_frame_state    (ev[`T1PM_EV_LOF]),
    .alignment_change_event (ev[`T1PM_EV_ALIGNMENT_CHANGE_EVENT]),
    .link_ctrl1_fcs_error   (ev[`T1PM_EV_FCS1]),
    .pattern_bit_error      (ev[`T1PM_EV_PAT]),
    .transmit_slip_event    (ev[`T1PM_EV_SLIP]),
    .irq                    (irq)
  );

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Whole run is under a thousand cycles; the ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      $display("ERROR at %0t: run did not finish in time", $time);
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One transfer; evt pulses event inputs in the cycle the access is taken
  task automatic apb(input logic wr, input logic [13:0] idx, input logic [1:0] lsb,
                     input logic [31:0] wd, input logic [4:0] evt);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, lsb};
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    ev      <= ev | evt;
    do begin
      @(posedge clk_sys);
      ev <= ev & ~evt;
      n  = n + 1;
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    // Answer comes after exactly one wait state
    check(n, 32'd2);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [13:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 2'b00, 32'h0, 5'h00);
    check(rd, exp);
    check(32'(err), 32'h0);
  endtask

  // Holds one event input high for n consecutive sampling edges
  task automatic burst(input int i, input int n);
    @(posedge clk_sys);
    ev[i] <= 1'b1;
    repeat (n) @(posedge clk_sys);
    ev[i] <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    rd_chk(`T1PM_IDX_LOF, 32'h0);
    rd_chk(`T1PM_IDX_ALIGNMENT_CHANGE_EVENT, 32'h0);
    rd_chk(`T1PM_IDX_FCS1, 32'h0);
    rd_chk(`T1PM_IDX_PAT_HI, 32'h0);
    rd_chk(`T1PM_IDX_PAT_LO, 32'h0);
    rd_chk(`T1PM_IDX_SLIP, 32'h0);
    rd_chk(`T1PM_IDX_IRQ_MASK, 32'h0);
    check(32'(irq), 32'h0);
    $display("test_reset done");
  endtask

  // Long losses still count once each; writes do not disturb counters
  task automatic test_lof();
    repeat (3) burst(`T1PM_EV_LOF, 6);
    apb(1'b1, `T1PM_IDX_LOF, 2'b00, 32'haa, 5'h00);
    check(32'(err), 32'h0);
    rd_chk(`T1PM_IDX_LOF, 32'h3);
    rd_chk(`T1PM_IDX_LOF, 32'h0);
    $display("test_lof done");
  endtask

  task automatic test_pulses();
    burst(`T1PM_EV_ALIGNMENT_CHANGE_EVENT, 5);
    burst(`T1PM_EV_FCS1, 7);
    burst(`T1PM_EV_SLIP, 1);
    rd_chk(`T1PM_IDX_ALIGNMENT_CHANGE_EVENT, 32'h5);
    rd_chk(`T1PM_IDX_FCS1, 32'h7);
    rd_chk(`T1PM_IDX_SLIP, 32'h1);
    rd_chk(`T1PM_IDX_SLIP, 32'h0);
    $display("test_pulses done");
  endtask

  // Wide counter: upper snapshot, latched low byte, clear by pair
  task automatic test_pattern();
    burst(`T1PM_EV_PAT, 300);
    rd_chk(`T1PM_IDX_PAT_HI, 32'h01);
    burst(`T1PM_EV_PAT, 2);
    rd_chk(`T1PM_IDX_PAT_LO, 32'h2c);
    rd_chk(`T1PM_IDX_PAT_HI, 32'h00);
    rd_chk(`T1PM_IDX_PAT_LO, 32'h02);
    burst(`T1PM_EV_PAT, 3);
    rd_chk(`T1PM_IDX_PAT_LO, 32'h03);
    rd_chk(`T1PM_IDX_PAT_LO, 32'h03);
    $display("test_pattern done");
  endtask

  // Saturation at full scale, then an event landing on the clearing read
  task automatic test_saturate();
    burst(`T1PM_EV_FCS1, 260);
    apb(1'b0, `T1PM_IDX_FCS1, 2'b00, 32'h0, 5'h04);
    check(rd, 32'hff);
    rd_chk(`T1PM_IDX_FCS1, 32'h01);
    $display("test_saturate done");
  endtask

  task automatic test_errors();
    apb(1'b0, 14'h0900, 2'b00, 32'h0, 5'h00);
    check(rd, 32'h0);
    check(32'(err), 32'h1);
    apb(1'b0, `T1PM_IDX_LOF, 2'b01, 32'h0, 5'h00);
    check(rd, 32'h0);
    check(32'(err), 32'h1);
    $display("test_errors done");
  endtask

  // Interrupt raised, cleared by status read, and held off by the mask
  task automatic test_irq();
    apb(1'b0, `T1PM_IDX_IRQ_STAT, 2'b00, 32'h0, 5'h00);
    apb(1'b1, `T1PM_IDX_IRQ_MASK, 2'b00, 32'h2, 5'h00);
    check(32'(err), 32'h0);
    check(32'(irq), 32'h0);
    rd_chk(`T1PM_IDX_IRQ_MASK, 32'h2);
    burst(`T1PM_EV_ALIGNMENT_CHANGE_EVENT, 1);
    @(posedge clk_sys);
    check(32'(irq), 32'h1);
    rd_chk(`T1PM_IDX_IRQ_STAT, 32'h2);
    @(posedge clk_sys);
    check(32'(irq), 32'h0);
    burst(`T1PM_EV_FCS1, 1);
    @(posedge clk_sys);
    check(32'(irq), 32'h0);
    rd_chk(`T1PM_IDX_IRQ_STAT, 32'h4);
    rd_chk(`T1PM_IDX_ALIGNMENT_CHANGE_EVENT, 32'h1);
    $display("test_irq done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    miscompares = 0;
    cmp_count   = 0;
    cycles      = 0;
    resetn      = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 16'h0000;
    pwdata      = 32'h0000_0000;
    ev          = 5'h00;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    test_reset();
    test_lof();
    test_pulses();
    test_pattern();
    test_saturate();
    test_errors();
    test_irq();
    print_verdict();
  end
endmodule // t1_perf_monitor_event_counters_test
